// [logic/tmw_timer.sv]
`include "tmw_defines.svh"
module tmw_timer import tmw_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       timer_tick,
	input  wire logic [1:0] waveform_mode_select,
	input  wire logic [1:0] compare_output_mode,
	input  wire logic       force_compare_strobe,
	input  wire logic       counter_wr,
	input  wire logic [7:0] counter_wdata,
	input  wire logic       compare_wr,
	input  wire logic [7:0] compare_wdata,
	input  wire logic       overflow_clr,
	input  wire logic       compare_match_clr,
	input  wire logic       pin_dir_out,
	input  wire logic       port_data,
	output logic      [7:0] counter_value,
	output logic      [7:0] compare_value,
	output logic      [7:0] compare_buffer,
	output logic            overflow_flag,
	output logic            compare_match_flag,
	output logic            compare_output_state,
	output logic            pin_out,
	output logic            pin_oe
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] ocr;
		logic [7:0] obuf;
		logic       down;
		logic       block;
		logic       match_pend;
		logic       tov;
		logic       ocf;
	} tmw_st_t;
	tmw_st_t   s_q, s_d;
	tmw_wave_t wm;
	logic      match;
	logic      is_pwm;
	tmw_cmp_if ev ();

	// ****************************************
	// Helper functions
	// ****************************************
	// Compare equality, used for the live match
	function automatic logic tmw_eq(
		input logic [7:0] a,
		input logic [7:0] b
	);
		return a == b;
	endfunction : tmw_eq

	// Counter sits at its maximum
	function automatic logic tmw_is_max(
		input logic [7:0] v
	);
		return v == `TMW_MAX;
	endfunction : tmw_is_max

	// Counter sits at bottom
	function automatic logic tmw_is_bottom(
		input logic [7:0] v
	);
		return v == `TMW_BOTTOM;
	endfunction : tmw_is_bottom

	// Count up by one; carry dropped, so 0xFF rolls to 0x00
	function automatic logic [7:0] tmw_inc(
		input logic [7:0] v
	);
		return v + 8'h01;
	endfunction : tmw_inc

	// Count down by one
	function automatic logic [7:0] tmw_dec(
		input logic [7:0] v
	);
		return v - 8'h01;
	endfunction : tmw_dec

	// Both PWM modes double buffer the compare value
	function automatic logic tmw_pwm_mode(
		input tmw_wave_t m
	);
		return (m == TMW_PCPWM) || (m == TMW_FAST);
	endfunction : tmw_pwm_mode

	// ****************************************
	// Mode decode and comparator
	// ****************************************
	logic at_max;
	logic at_bottom;

	assign wm        = tmw_wave_t'(waveform_mode_select);
	assign is_pwm    = tmw_pwm_mode(wm);
	assign at_max    = tmw_is_max(s_q.cnt);
	assign at_bottom = tmw_is_bottom(s_q.cnt);
	// Blocked for one tick after a counter write
	assign match     = tmw_eq(s_q.cnt, s_q.ocr) && !s_q.block;

	// Events for the waveform unit; bottom action fires as MAX rolls over
	assign ev.match     = match;
	assign ev.at_bottom = at_max;
	assign ev.up        = !s_q.down;
	assign ev.pwm       = is_pwm;
	assign ev.dual      = (wm == TMW_PCPWM);

	// ****************************************
	// Counter, buffer and flags
	// ****************************************
	always_comb begin
		logic [7:0] nxt;
		logic       wrap;
		logic       turn;
		nxt  = s_q.cnt;
		wrap = 1'b0;
		turn = 1'b0;
		s_d  = s_q;
		// Counting sequence from mode select alone
		if (timer_tick) begin
			unique case (wm)
				TMW_NORMAL: begin
					// Free run, never cleared
					nxt  = tmw_inc(s_q.cnt);
					// Overflow as the counter becomes zero
					wrap = at_max;
				end
				TMW_CTC: begin
					// Clear on match; else run on through 0xFF
					if (match) begin
						nxt = `TMW_BOTTOM;
					end else begin
						nxt = tmw_inc(s_q.cnt);
					end
					// Overflow only on the roll from MAX
					wrap = at_max;
				end
				TMW_FAST: begin
					// Single slope, cleared on the tick after MAX
					nxt  = tmw_inc(s_q.cnt);
					wrap = at_max;
					// New compare value taken as the period ends
					if (at_max) begin
						s_d.ocr = s_q.obuf;
					end
				end
				TMW_PCPWM: begin
					// Turn at MAX and BOTTOM, each end shown for one tick
					if (!s_q.down) begin
						turn = at_max;
						if (turn) begin
							nxt = tmw_dec(s_q.cnt);
						end else begin
							nxt = tmw_inc(s_q.cnt);
						end
					end else begin
						turn = at_bottom;
						if (turn) begin
							nxt = tmw_inc(s_q.cnt);
						end else begin
							nxt = tmw_dec(s_q.cnt);
						end
					end
					if (turn) begin
						s_d.down = !s_q.down;
					end
					// Buffer copied at MAX, as in fast mode
					if (at_max) begin
						s_d.ocr = s_q.obuf;
					end
					// Overflow as the down slope reaches zero
					wrap = tmw_is_bottom(nxt);
				end
			endcase
			s_d.block      = 1'b0;
			s_d.match_pend = match;
			s_d.cnt        = nxt;
		end
		// Direction only means something in dual slope
		if (wm != TMW_PCPWM) begin
			s_d.down = 1'b0;
		end
		// Compare flag one tick after the match; set beats clear
		if (timer_tick && s_q.match_pend) begin
			s_d.ocf = 1'b1;
		end else if (compare_match_clr) begin
			s_d.ocf = 1'b0;
		end
		// Overflow only set by counting; set beats clear
		if (wrap) begin
			s_d.tov = 1'b1;
		end else if (overflow_clr) begin
			s_d.tov = 1'b0;
		end
		// Compare write: buffered in PWM, direct otherwise
		if (compare_wr) begin
			s_d.obuf = compare_wdata;
			if (!is_pwm) begin
				s_d.ocr = compare_wdata;
			end
		end
		// Buffer tracks the live value outside PWM, so PWM entry starts clean
		if (!is_pwm && !compare_wr) begin
			s_d.obuf = s_q.ocr;
		end
		// Software counter write overrides counting
		if (counter_wr) begin
			s_d.cnt        = counter_wdata;
			s_d.block      = 1'b1;
			s_d.match_pend = 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{cnt: `TMW_CNT_RESET, ocr: `TMW_OCR_RESET, obuf: `TMW_OCR_RESET,
			         default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Waveform unit
	// ****************************************
	tmw_wavegen u_wave (
		.core_clk             (core_clk),
		.reset_n              (reset_n),
		.timer_tick           (timer_tick),
		.compare_output_mode  (compare_output_mode),
		.force_compare_strobe (force_compare_strobe),
		.ev                   (ev),
		.state_o              (compare_output_state)
	);

	// Pin override only when mode is nonzero; driver by direction
	assign pin_out = (compare_output_mode != `TMW_COM_NONE) ? compare_output_state
	                                                        : port_data;
	assign pin_oe  = pin_dir_out;

	assign counter_value      = s_q.cnt;
	assign compare_value      = s_q.ocr;
	assign compare_buffer     = s_q.obuf;
	assign overflow_flag      = s_q.tov;
	assign compare_match_flag = s_q.ocf;
endmodule : tmw_timer

// [logic/tmw_defines.svh]
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH

// ****************************************
// Encodings and limits
// ****************************************
`define TMW_WGM_NORMAL 2'h0
`define TMW_WGM_PCPWM  2'h1
`define TMW_WGM_CTC    2'h2
`define TMW_WGM_FAST   2'h3
`define TMW_COM_NONE   2'h0
`define TMW_COM_TOGGLE 2'h1
`define TMW_COM_CLEAR  2'h2
`define TMW_COM_SET    2'h3
`define TMW_BOTTOM     8'h00
`define TMW_MAX        8'hFF
`define TMW_CNT_RESET  8'h00
`define TMW_OCR_RESET  8'h00
`endif

// [logic/tmw_pkg.sv]
package tmw_pkg;
	typedef enum logic [1:0] {
		TMW_NORMAL = 2'b00,
		TMW_PCPWM  = 2'b01,
		TMW_CTC    = 2'b10,
		TMW_FAST   = 2'b11
	} tmw_wave_t;
endpackage : tmw_pkg

// [logic/tmw_cmp_if.sv]
// ****************************************
// Compare events between counter and waveform unit
// ****************************************
interface tmw_cmp_if;
	logic match;
	logic at_bottom;
	logic up;
	logic pwm;
	logic dual;
	modport cnt (output match, output at_bottom, output up, output pwm, output dual);
	modport wave (input match, input at_bottom, input up, input pwm, input dual);
endinterface : tmw_cmp_if

// [logic/tmw_wavegen.sv]
`include "tmw_defines.svh"
module tmw_wavegen import tmw_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       timer_tick,
	input  wire logic [1:0] compare_output_mode,
	input  wire logic       force_compare_strobe,
	tmw_cmp_if.wave         ev,
	output logic            state_o
);
	typedef struct packed {
		logic oc;
	} tmw_wg_t;
	tmw_wg_t s_q, s_d;

	// ****************************************
	// Output-compare state update
	// ****************************************
	always_comb begin
		logic act;
		act = 1'b0;
		s_d = s_q;
		// Mode bits read live, so a new value hits the next match
		if (!ev.pwm) begin
			act = (timer_tick && ev.match) || force_compare_strobe;
			if (act) begin
				unique case (compare_output_mode)
					`TMW_COM_NONE:   s_d.oc = s_q.oc;
					`TMW_COM_TOGGLE: s_d.oc = ~s_q.oc;
					`TMW_COM_CLEAR:  s_d.oc = 1'b0;
					`TMW_COM_SET:    s_d.oc = 1'b1;
				endcase
			end
		end else if (timer_tick && compare_output_mode != `TMW_COM_NONE) begin
			if (ev.dual) begin
				// Up match clears, down match sets for non-inverting
				if (ev.match && compare_output_mode[1])
					s_d.oc = compare_output_mode[0] ^ ~ev.up;
			end else if (compare_output_mode == `TMW_COM_TOGGLE) begin
				if (ev.match)
					s_d.oc = ~s_q.oc;
			end else if (ev.match) begin
				// Match wins over bottom: with clear on match, a compare of MAX keeps the level cleared
				s_d.oc = compare_output_mode[0];
			end else if (ev.at_bottom) begin
				s_d.oc = ~compare_output_mode[0];
			end
		end
	end

	// State flop
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign state_o = s_q.oc;
endmodule : tmw_wavegen

// [verif/tmw_load.sv]
// ****************************************
// Load on the compare output pin
// ****************************************
module tmw_load (
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up wins while undriven, so a stale value never passes
	assign level = pin_oe ? pin_out : 1'h1;
endmodule : tmw_load

// [verif/tmw_timer_sva.sv]
// ****************************************
// Port checker
// ****************************************
module tmw_timer_sva (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic       timer_tick,
	input wire logic [1:0] waveform_mode_select,
	input wire logic [1:0] compare_output_mode,
	input wire logic       force_compare_strobe,
	input wire logic       counter_wr,
	input wire logic [7:0] counter_wdata,
	input wire logic       compare_wr,
	input wire logic [7:0] compare_wdata,
	input wire logic       overflow_clr,
	input wire logic       pin_dir_out,
	input wire logic       port_data,
	input wire logic [7:0] counter_value,
	input wire logic [7:0] compare_value,
	input wire logic [7:0] compare_buffer,
	input wire logic       overflow_flag,
	input wire logic       compare_output_state,
	input wire logic       pin_out,
	input wire logic       pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	pin_dir_a: assert property (pin_oe == pin_dir_out) else $error("pin enable wrong");
	pin_src_a: assert property (pin_out == ((compare_output_mode != 2'h0) ?
		compare_output_state : port_data)) else $error("pin source wrong");
	max_wrap_a: assert property (timer_tick && !counter_wr && counter_value == 8'hFF &&
		(waveform_mode_select == 2'h0 || waveform_mode_select == 2'h3)
		|=> counter_value == 8'h00 && overflow_flag) else $error("no wrap at max");
	ovf_keep_a: assert property (overflow_flag && !overflow_clr |=> overflow_flag)
		else $error("overflow lost");
	ovf_clr_a: assert property (overflow_clr && !timer_tick |=> !overflow_flag)
		else $error("overflow not cleared");
	cnt_write_a: assert property (counter_wr |=> counter_value == $past(counter_wdata))
		else $error("counter write lost");
	force_act_a: assert property (force_compare_strobe && waveform_mode_select == 2'h0 &&
		compare_output_mode[1] |=> compare_output_state == $past(compare_output_mode[0]))
		else $error("force action wrong");
	mode_none_a: assert property (compare_output_mode == 2'h0 |=>
		$stable(compare_output_state)) else $error("state moved with no action");
	cmp_buf_a: assert property (waveform_mode_select == 2'h3 && compare_wr && !timer_tick
		|=> compare_buffer == $past(compare_wdata) && $stable(compare_value))
		else $error("compare not buffered");
endmodule : tmw_timer_sva

bind tmw_timer tmw_timer_sva i_sva (.core_clk, .reset_n, .timer_tick, .waveform_mode_select,
	.compare_output_mode, .force_compare_strobe, .counter_wr, .counter_wdata, .compare_wr,
	.compare_wdata, .overflow_clr, .pin_dir_out, .port_data, .counter_value, .compare_value,
	.compare_buffer, .overflow_flag, .compare_output_state, .pin_out, .pin_oe);

// [verif/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk = 1'h0, reset_n = 1'h0, timer_tick = 1'h0, force_compare_strobe = 1'h0;
	logic       counter_wr = 1'h0, compare_wr = 1'h0, overflow_clr = 1'h0, compare_match_clr = 1'h0;
	logic       pin_dir_out = 1'h0, port_data = 1'h0;
	logic [1:0] waveform_mode_select = 2'h0, compare_output_mode = 2'h0;
	logic [7:0] counter_wdata = 8'h00, compare_wdata = 8'h00;
	logic [7:0] counter_value, compare_value, compare_buffer;
	logic       overflow_flag, compare_match_flag, compare_output_state, pin_out, pin_oe, level;
	int         n_mismatch = 0, checks = 0, cyc = 0;

	always #5 core_clk = ~core_clk;
	tmw_timer i_dut (.core_clk, .reset_n, .timer_tick, .waveform_mode_select,
		.compare_output_mode, .force_compare_strobe, .counter_wr, .counter_wdata, .compare_wr,
		.compare_wdata, .overflow_clr, .compare_match_clr, .pin_dir_out, .port_data,
		.counter_value, .compare_value, .compare_buffer, .overflow_flag, .compare_match_flag,
		.compare_output_state, .pin_out, .pin_oe);
	tmw_load i_load (.pin_out, .pin_oe, .level);

	// ****************************************
	// Access tasks
	// ****************************************
	// Strobe selectors for pls
	localparam int P_CNT = 0;
	localparam int P_CMP = 1;
	localparam int P_OVF = 2;
	localparam int P_OCF = 3;
	localparam int P_FRC = 4;
	// pls and tick end 1 ns past their last edge so results have landed
	task automatic pls(input int k, input logic [7:0] v);
		@(posedge core_clk) begin
			counter_wr           <= (k == P_CNT);
			compare_wr           <= (k == P_CMP);
			overflow_clr         <= (k == P_OVF);
			compare_match_clr    <= (k == P_OCF);
			force_compare_strobe <= (k == P_FRC);
			counter_wdata        <= (k == P_CNT) ? v : counter_wdata;
			compare_wdata        <= (k == P_CMP) ? v : compare_wdata;
		end
		@(posedge core_clk) begin
			counter_wr           <= 1'h0;
			compare_wr           <= 1'h0;
			overflow_clr         <= 1'h0;
			compare_match_clr    <= 1'h0;
			force_compare_strobe <= 1'h0;
		end
		#1;
	endtask : pls
	task automatic tick(input int n);
		@(posedge core_clk) timer_tick <= 1'h1;
		repeat (n) @(posedge core_clk);
		timer_tick <= 1'h0;
		#1;
	endtask : tick
	task automatic setm(input logic [1:0] w, input logic [1:0] c);
		@(posedge core_clk) waveform_mode_select <= w;
		compare_output_mode <= c;
	endtask : setm
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'h1;
		pls(P_CNT, 8'hFE);
		tick(2);
		chk(counter_value, 8'h00);
		chk({7'h0, overflow_flag}, 8'h01);
		pls(P_OVF, 8'h00);
		chk({7'h0, overflow_flag}, 8'h00);
		$display("normal test done");
		setm(2'h2, 2'h1);
		pls(P_CMP, 8'h03);
		pls(P_CNT, 8'h00);
		tick(4);
		chk(counter_value, 8'h00);
		chk({7'h0, compare_output_state}, 8'h01);
		tick(1);
		chk({7'h0, compare_match_flag}, 8'h01);
		pls(P_OCF, 8'h00);
		// Counter written equal to compare: the next match is swallowed
		pls(P_CNT, 8'h03);
		tick(2);
		chk(counter_value, 8'h05);
		chk({7'h0, compare_output_state}, 8'h01);
		chk({7'h0, compare_match_flag}, 8'h00);
		$display("clear on match test done");
		setm(2'h0, 2'h2);
		pls(P_FRC, 8'h00);
		chk({7'h0, compare_output_state}, 8'h00);
		setm(2'h0, 2'h3);
		pls(P_FRC, 8'h00);
		chk({7'h0, compare_output_state}, 8'h01);
		setm(2'h0, 2'h2);
		pls(P_FRC, 8'h00);
		chk({7'h0, level}, 8'h01);
		@(posedge core_clk) pin_dir_out <= 1'h1;
		#1;
		chk({7'h0, level}, 8'h00);
		$display("force test done");
		setm(2'h3, 2'h2);
		pls(P_CMP, 8'hFF);
		chk(compare_value, 8'h03);
		pls(P_CNT, 8'hFE);
		tick(2);
		chk(counter_value, 8'h00);
		chk({7'h0, overflow_flag}, 8'h01);
		chk(compare_value, 8'hFF);
		chk({7'h0, compare_output_state}, 8'h01);
		// Compare at MAX: the match at MAX wins, level goes from set to cleared
		tick(256);
		chk({7'h0, compare_output_state}, 8'h00);
		$display("fast pwm test done");
		setm(2'h1, 2'h2);
		pls(P_CMP, 8'h02);
		pls(P_CNT, 8'hFE);
		tick(2);
		chk(counter_value, 8'hFE);
		chk(compare_value, 8'h02);
		pls(P_OVF, 8'h00);
		pls(P_CNT, 8'h03);
		tick(2);
		chk({7'h0, compare_output_state}, 8'h01);
		tick(4);
		chk(counter_value, 8'h03);
		chk({7'h0, overflow_flag}, 8'h01);
		chk({7'h0, compare_output_state}, 8'h00);
		$display("phase correct test done");
		end_sim();
	end
endmodule : testbench
